// File: inc/fpec_regs.svh
/*
  register offsets, field positions, reset values and array map constants
  for the flash program/erase control block.
  assumes: included by bare name from the design file.
*/
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH

// register byte addresses
`define FPEC_LOCK_ADDR       16'h00F4
`define FPEC_CFG_ADDR        16'h00F5
`define FPEC_TEST_ADDR       16'h00F6
`define FPEC_CTRL_ADDR       16'h00F7

// flash_control_reg fields
`define FPEC_CTRL_HV_BIT     0
`define FPEC_CTRL_LATCH_BIT  1
`define FPEC_CTRL_ERASE_BIT  2
`define FPEC_CTRL_VSTAT_BIT  3

// configuration and test fields
`define FPEC_CFG_BOOT_PROTECT_BIT   0
`define FPEC_TEST_VLO_BIT    3

// reset values
`define FPEC_BOOT_PROTECT_RESET     1'b1
`define FPEC_CTRL_RESET      1'b0

// array map
`define FPEC_ARRAY_BASE      16'hC000
`define FPEC_ARRAY_BYTES     17'h0_4000
`define FPEC_BOOT_BYTES      17'h0_0800
`define FPEC_ERASED_BYTE     8'hFF

`endif

// File: inc/fpec_pkg.sv
/*
  types shared by the flash program/erase control block.
  assumes: compiled before the design file; nothing imports it.
*/
package fpec_pkg;

  // read path sequencing
  typedef enum logic [1:0] {
    FPEC_RD_IDLE = 2'b00,
    FPEC_RD_MIS  = 2'b01
  } fpec_rd_type;

  // one bus request as seen by the block
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        byteSize;
  } fpec_req_type;

  // whole state of the control block
  typedef struct packed {
    logic        vSync1;
    logic        vSync2;
    logic        eraseSel;
    logic        latchEn;
    logic        hvApply;
    logic        bootProt;
    logic        voltOverride;
    logic        captured;
    logic [15:0] latAddr;
    logic [15:0] latData;
    logic        latByte;
    logic [12:0] sweep;
    logic [15:0] rdata;
    logic        rdValid;
    logic        busy;
    logic [7:0]  misHi;
    logic [15:0] misAddr;
    fpec_rd_type rdState;
  } fpec_state_type;

endpackage

// File: rtl/fpec_flash_ctrl.sv
/*
  flash program/erase sequencer: control bits, interlocks, programming
  latches, array storage with program/erase effects and read modes.
  assumes: one 50 MHz clock, a bus master keeping the plain strobe port
  protocol, software doing all pulse timing, test mode from same clock.
*/
// Added by the designer: the plain strobed port and the address map.
`include "fpec_regs.svh"

module fpec_flash_ctrl #(
  parameter int ARRAY_WORDS = 8192
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic [15:0] busAddr,
  input  wire logic [15:0] busWdata,
  input  wire logic        busWr,
  input  wire logic        busRd,
  input  wire logic        byteSizeFlag,
  input  wire logic        testMode,
  input  wire logic        programVoltagePin,
  output logic      [15:0] busRdata,
  output logic             busRdValid,
  output logic             busBusy,
  output logic             hvApplyOut,
  output logic             eraseSelOut
);

  localparam int IW = $clog2(ARRAY_WORDS);

  // storage: even (high) and odd (low) byte banks, not reset
  logic [7:0] evenBank [ARRAY_WORDS];
  logic [7:0] oddBank  [ARRAY_WORDS];

  fpec_pkg::fpec_state_type st_ff;
  fpec_pkg::fpec_state_type nxt_st;
  fpec_pkg::fpec_req_type   req;

  logic [16:0]   reqOff;
  logic          reqInArray;
  logic [IW-1:0] reqIdx;
  logic [IW-1:0] reqIdxNext;
  logic [16:0]   latOff;
  logic [IW-1:0] latIdx;
  logic          latInBoot;
  logic          sweepInBoot;
  logic          voltOk;
  logic          doProgram;
  logic          doErase;

  // bundle the bus request
  always_comb begin
    req.addr     = busAddr;
    req.wdata    = busWdata;
    req.wr       = busWr;
    req.rd       = busRd;
    req.byteSize = byteSizeFlag;
  end

  // array address decode, top word holds the reset vector
  always_comb begin
    reqOff      = {1'b0, req.addr} - {1'b0, `FPEC_ARRAY_BASE};
    reqInArray  = ({1'b0, req.addr} >= {1'b0, `FPEC_ARRAY_BASE})
                  && (reqOff < `FPEC_ARRAY_BYTES);
    reqIdx      = reqOff[IW:1];
    reqIdxNext  = IW'(reqOff[IW:1] + 1'b1);
    latOff      = {1'b0, st_ff.latAddr} - {1'b0, `FPEC_ARRAY_BASE};
    latIdx      = latOff[IW:1];
    latInBoot   = latOff >= (`FPEC_ARRAY_BYTES - `FPEC_BOOT_BYTES);
    sweepInBoot = {3'b000, st_ff.sweep, 1'b0}
                  >= (`FPEC_ARRAY_BYTES - `FPEC_BOOT_BYTES);
  end

  // voltage applied while hv set and latch held, unless the target lies in the protected boot block
  always_comb begin
    voltOk    = st_ff.vSync2 | st_ff.voltOverride;
    doProgram = st_ff.hvApply && st_ff.latchEn && st_ff.captured
                && !st_ff.eraseSel
                && !(st_ff.bootProt && latInBoot);
    doErase   = st_ff.hvApply && st_ff.latchEn && st_ff.captured
                && st_ff.eraseSel
                && !(st_ff.bootProt && sweepInBoot);
  end

  // next state: registers, interlocks, capture, reads
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.vSync1  = programVoltagePin;
    nxt_st.vSync2  = st_ff.vSync1;
    nxt_st.rdValid = 1'b0;
    // erase sweep walks one word per cycle while voltage applied
    if (st_ff.hvApply && st_ff.eraseSel) begin
      nxt_st.sweep = st_ff.sweep + 13'h0001;
    end else begin
      nxt_st.sweep = 13'h0000;
    end
    if (!testMode) begin
      nxt_st.voltOverride = 1'b0;
    end

    // second half of a misaligned word read
    if (st_ff.rdState == fpec_pkg::FPEC_RD_MIS) begin
      nxt_st.rdata   = {st_ff.misHi, evenBank[reqIdxNextOf(st_ff.misAddr)]};
      nxt_st.rdValid = 1'b1;
      nxt_st.busy    = 1'b0;
      nxt_st.rdState = fpec_pkg::FPEC_RD_IDLE;
    end else if (req.wr) begin
      case (req.addr)
        `FPEC_CTRL_ADDR: begin
          if (st_ff.hvApply) begin
            // only hv may change now
            nxt_st.hvApply = req.wdata[`FPEC_CTRL_HV_BIT];
          end else begin
            nxt_st.eraseSel = req.wdata[`FPEC_CTRL_ERASE_BIT];
            nxt_st.latchEn  = req.wdata[`FPEC_CTRL_LATCH_BIT]
                              && (st_ff.latchEn || voltOk);
            // hv needs latch held and a capture since it rose
            nxt_st.hvApply  = req.wdata[`FPEC_CTRL_HV_BIT]
                              && req.wdata[`FPEC_CTRL_LATCH_BIT]
                              && st_ff.latchEn
                              && st_ff.captured;
            if (!(req.wdata[`FPEC_CTRL_LATCH_BIT] && st_ff.latchEn)) begin
              nxt_st.captured = 1'b0;
            end
          end
        end
        `FPEC_CFG_ADDR: begin
          if (!st_ff.hvApply) begin
            nxt_st.bootProt = req.wdata[`FPEC_CFG_BOOT_PROTECT_BIT];
          end
        end
        `FPEC_TEST_ADDR: begin
          nxt_st.voltOverride = testMode
                                && req.wdata[`FPEC_TEST_VLO_BIT];
        end
        default: begin
          // capture once per latch period, else writes dropped
          if (reqInArray && st_ff.latchEn && !st_ff.captured
              && !st_ff.hvApply) begin
            nxt_st.captured = 1'b1;
            nxt_st.latAddr  = req.addr;
            nxt_st.latData  = req.wdata;
            nxt_st.latByte  = req.byteSize | req.addr[0];
          end
        end
      endcase
    end else if (req.rd) begin
      nxt_st.rdValid = 1'b1;
      case (req.addr)
        `FPEC_CTRL_ADDR: begin
          nxt_st.rdata = {12'h000, st_ff.vSync2, st_ff.eraseSel,
                          st_ff.latchEn, st_ff.hvApply};
        end
        `FPEC_CFG_ADDR: begin
          nxt_st.rdata = {15'h0000, st_ff.bootProt};
        end
        `FPEC_TEST_ADDR: begin
          nxt_st.rdata = {12'h000, st_ff.voltOverride, 3'b000};
        end
        `FPEC_LOCK_ADDR: begin
          nxt_st.rdata = 16'h0000;
        end
        default: begin
          if (!reqInArray) begin
            nxt_st.rdata = 16'h0000;
          end else if (st_ff.hvApply) begin
            nxt_st.rdValid = 1'b0;
          end else if (st_ff.latchEn && !st_ff.eraseSel
                       && st_ff.captured) begin
            // location being programmed
            nxt_st.rdata = st_ff.latByte
              ? {8'h00, st_ff.latAddr[0] ? oddBank[latIdx]
                                         : evenBank[latIdx]}
              : {evenBank[latIdx], oddBank[latIdx]};
          end else if (req.byteSize) begin
            nxt_st.rdata = {8'h00, req.addr[0] ? oddBank[reqIdx]
                                               : evenBank[reqIdx]};
          end else if (!req.addr[0]) begin
            nxt_st.rdata = {evenBank[reqIdx], oddBank[reqIdx]};
          end else begin
            // misaligned word: one extra cycle
            nxt_st.rdValid = 1'b0;
            nxt_st.busy    = 1'b1;
            nxt_st.misHi   = oddBank[reqIdx];
            nxt_st.misAddr = req.addr;
            nxt_st.rdState = fpec_pkg::FPEC_RD_MIS;
          end
        end
      endcase
    end
  end

  // index of the word after a misaligned address
  function automatic logic [IW-1:0] reqIdxNextOf(input logic [15:0] a);
    logic [16:0] off;
    off = {1'b0, a} - {1'b0, `FPEC_ARRAY_BASE};
    return IW'(off[IW:1] + 1'b1);
  endfunction

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff          <= '0;
      st_ff.bootProt <= `FPEC_BOOT_PROTECT_RESET;
      st_ff.eraseSel <= `FPEC_CTRL_RESET;
      st_ff.latchEn  <= `FPEC_CTRL_RESET;
      st_ff.hvApply  <= `FPEC_CTRL_RESET;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  // array cells: program only clears bits, erase only sets them
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (doProgram) begin
        if (st_ff.latByte) begin
          if (st_ff.latAddr[0]) begin
            oddBank[latIdx]  <= oddBank[latIdx]
                                & st_ff.latData[7:0];
          end else begin
            evenBank[latIdx] <= evenBank[latIdx]
                                & st_ff.latData[7:0];
          end
        end else begin
          evenBank[latIdx] <= evenBank[latIdx] & st_ff.latData[15:8];
          oddBank[latIdx]  <= oddBank[latIdx] & st_ff.latData[7:0];
        end
      end else if (doErase) begin
        evenBank[st_ff.sweep[IW-1:0]] <= `FPEC_ERASED_BYTE;
        oddBank[st_ff.sweep[IW-1:0]]  <= `FPEC_ERASED_BYTE;
      end
    end
  end

  // outputs straight from the state register
  assign busRdata    = st_ff.rdata;
  assign busRdValid  = st_ff.rdValid;
  assign busBusy     = st_ff.busy;
  assign hvApplyOut  = st_ff.hvApply;
  assign eraseSelOut = st_ff.eraseSel;

endmodule // fpec_flash_ctrl

// File: tb/fpec_flash_checker.sv
/*
  port checker for the flash program/erase control block.
  assumes: bound to fpec_flash_ctrl, one clock, reset_n async low.
*/
module fpec_flash_checker #(
  parameter int ARRAY_WORDS = 8192
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        clkEn,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic        byteSizeFlag,
  input wire logic        testMode,
  input wire logic        programVoltagePin,
  input wire logic [15:0] busRdata,
  input wire logic        busRdValid,
  input wire logic        busBusy,
  input wire logic        hvApplyOut,
  input wire logic        eraseSelOut
);
  timeunit 1ns;
  timeprecision 1ns;
  // decoded requests taken by the block
  logic rdReq;
  logic ctlWr;
  assign rdReq = clkEn && busRd && !busBusy;
  assign ctlWr = clkEn && busWr && !busBusy && busAddr == 16'h00F7;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // answer steps
  sequence s_one;
    busRdValid && !busBusy;
  endsequence
  sequence s_mis;
    busBusy ##1 s_one;
  endsequence
  property p_ctl_rd;
    rdReq && busAddr == 16'h00F7 |=> s_one;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read lost");
  property p_hv_rise;
    $rose(hvApplyOut) |-> $past(ctlWr && busWdata[0] && busWdata[1]);
  endproperty
  a_hv_rise: assert property (p_hv_rise) else $error("hv rose unasked");
  property p_hv_fall;
    $fell(hvApplyOut) |-> $past(ctlWr && !busWdata[0]);
  endproperty
  a_hv_fall: assert property (p_hv_fall) else $error("hv fell unasked");
  property p_era;
    $changed(eraseSelOut) |-> $past(ctlWr && !hvApplyOut);
  endproperty
  a_era: assert property (p_era) else $error("erase bit moved");
  property p_hv_rd;
    rdReq && hvApplyOut && busAddr[15:14] == 2'b11 |=> !busRdValid;
  endproperty
  a_hv_rd: assert property (p_hv_rd) else $error("read not ignored");
  property p_mis;
    rdReq && !hvApplyOut && !byteSizeFlag && busAddr[0]
      && busAddr[15:14] == 2'b11 |=> s_mis;
  endproperty
  a_mis: assert property (p_mis) else $error("misaligned timing");
  property p_aln;
    rdReq && !hvApplyOut && (byteSizeFlag || !busAddr[0]) |=> s_one;
  endproperty
  a_aln: assert property (p_aln) else $error("aligned timing");
  property p_rdv;
    busRdValid |-> $past(rdReq || busBusy);
  endproperty
  a_rdv: assert property (p_rdv) else $error("stray read valid");
endmodule // fpec_flash_checker

bind fpec_flash_ctrl fpec_flash_checker #(.ARRAY_WORDS(ARRAY_WORDS))
  i_chk (.*);

// File: tb/fpec_cpu_model.sv
/*
  cpu bus master model running program and erase software.
  assumes: plain strobe port, read data one cycle after the strobe, two for a misaligned word.
*/
module fpec_cpu_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] busRdata,
  input  wire logic        busRdValid,
  output logic      [15:0] busAddr,
  output logic      [15:0] busWdata,
  output logic             busWr,
  output logic             busRd,
  output logic             byteSizeFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus from time zero
  initial begin
    busAddr = 16'h0000;
    busWdata = 16'h0000;
    busWr = 1'b0;
    busRd = 1'b0;
    byteSizeFlag = 1'b0;
  end
  // one write cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic b);
    @(posedge ref_clk);
    busAddr <= a;
    busWdata <= d;
    byteSizeFlag <= b;
    busWr <= 1'b1;
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask
  // one read cycle, answer awaited for two cycles at most
  task automatic rd(input logic [15:0] a, input logic b,
                    output logic [15:0] q, output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    @(posedge ref_clk);
    busAddr <= a;
    byteSizeFlag <= b;
    busRd <= 1'b1;
    @(posedge ref_clk);
    busRd <= 1'b0;
    for (int n = 0; n < 2 && !ok; n++) begin
      @(negedge ref_clk);
      ok = (busRdValid === 1'b1);
      q = busRdata;
    end
  endtask
  // program one location: latch, capture, pulse, settle
  task automatic prog(input logic [15:0] a, input logic [15:0] d,
                      input logic b);
    wr(16'h00F7, 16'h0002, 1'b1);
    wr(a, d, b);
    wr(16'h00F7, 16'h0003, 1'b1);
    repeat (2) @(posedge ref_clk);
    wr(16'h00F7, 16'h0002, 1'b1);
    repeat (2) @(posedge ref_clk); // settle before verify
    wr(16'h00F7, 16'h0000, 1'b1);
  endtask
  // bulk erase with one long pulse
  task automatic erase(input int cycles);
    wr(16'h00F7, 16'h0006, 1'b1);
    wr(16'hC000, 16'h0000, 1'b0);
    wr(16'h00F7, 16'h0007, 1'b1);
    repeat (cycles) @(posedge ref_clk);
    wr(16'h00F7, 16'h0006, 1'b1);
    wr(16'h00F7, 16'h0000, 1'b1);
  endtask
endmodule // fpec_cpu_model

// File: tb/testbench.sv
/*
  self-checking bench for the flash program/erase control block.
  assumes: array shrunk to 64 words at C000, pin voltage driven here.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WORDS = 64;
  typedef struct {
    logic [15:0] a;
    logic [15:0] d;
    logic        b;
    logic [15:0] e;
  } fpec_row_type;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        programVoltagePin = 1'b1;
  logic        clkEn = 1'b1;
  logic        testMode = 1'b0;
  logic [15:0] busAddr, busWdata, busRdata;
  logic        busWr, busRd, byteSizeFlag, busRdValid, busBusy;
  logic        hvApplyOut, eraseSelOut;
  int          bad_count = 0;
  int          cmp_count = 0;
  // program then read back; third row only clears bits
  fpec_row_type rows [4] = '{
    '{16'hC002, 16'h1234, 1'b0, 16'h1234},
    '{16'hC004, 16'h00A5, 1'b1, 16'h00A5},
    '{16'hC002, 16'hFF00, 1'b0, 16'h1200},
    '{16'hC007, 16'h003C, 1'b1, 16'h003C}};
  fpec_flash_ctrl #(.ARRAY_WORDS(WORDS)) i_fpec_flash_ctrl (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .byteSizeFlag(byteSizeFlag), .testMode(testMode),
    .programVoltagePin(programVoltagePin), .busRdata(busRdata),
    .busRdValid(busRdValid), .busBusy(busBusy),
    .hvApplyOut(hvApplyOut), .eraseSelOut(eraseSelOut));
  fpec_cpu_model i_fpec_cpu_model (
    .ref_clk(ref_clk), .busRdata(busRdata), .busRdValid(busRdValid),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .byteSizeFlag(byteSizeFlag));
  always #10 ref_clk = ~ref_clk;
  // verdict and end of run
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic b);
    i_fpec_cpu_model.wr(a, d, b);
  endtask
  // read with expected data and whether an answer comes
  task automatic rdc(input logic [15:0] a, input logic b,
                     input logic [15:0] e, input logic v);
    logic [15:0] q;
    logic        ok;
    i_fpec_cpu_model.rd(a, b, q, ok);
    chk({15'h0000, ok}, {15'h0000, v});
    if (v && ok) chk(q, e);
    else if (v) conclude();
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdc(16'h00F7, 1'b1, 16'h0008, 1'b1);
    rdc(16'h00F5, 1'b1, 16'h0001, 1'b1);
    i_fpec_cpu_model.erase(WORDS + 8);
    rdc(16'hC010, 1'b0, 16'hFFFF, 1'b1);
    foreach (rows[i]) begin
      i_fpec_cpu_model.prog(rows[i].a, rows[i].d, rows[i].b);
      rdc(rows[i].a, rows[i].b, rows[i].e, 1'b1);
    end
    wr(16'h00F7, 16'h0002, 1'b1);
    wr(16'h00F7, 16'h0003, 1'b1);
    rdc(16'h00F7, 1'b1, 16'h000A, 1'b1);
    wr(16'hC010, 16'h0000, 1'b0);
    wr(16'hC012, 16'h0000, 1'b0);
    wr(16'h00F7, 16'h0003, 1'b1);
    rdc(16'h00F7, 1'b1, 16'h000B, 1'b1);
    chk({15'h0000, hvApplyOut}, 16'h0001);
    chk({15'h0000, eraseSelOut}, 16'h0000);
    wr(16'h00F7, 16'h0001, 1'b1);
    rdc(16'h00F7, 1'b1, 16'h000B, 1'b1);
    rdc(16'hC010, 1'b0, 16'h0000, 1'b0);
    wr(16'h00F7, 16'h0002, 1'b1);
    rdc(16'hC012, 1'b0, 16'h0000, 1'b1);
    wr(16'h00F7, 16'h0000, 1'b1);
    rdc(16'hC012, 1'b0, 16'hFFFF, 1'b1);
    wr(16'h00F7, 16'h0001, 1'b1);
    rdc(16'h00F7, 1'b1, 16'h0008, 1'b1);
    wr(16'hC020, 16'h0000, 1'b0);
    rdc(16'hC020, 1'b0, 16'hFFFF, 1'b1);
    rdc(16'hC003, 1'b0, 16'h00A5, 1'b1);
    rdc(16'h0100, 1'b0, 16'h0000, 1'b1);
    // write while the clock enable is low must be lost
    @(posedge ref_clk) clkEn <= 1'b0;
    wr(16'h00F7, 16'h0002, 1'b1);
    @(posedge ref_clk) clkEn <= 1'b1;
    rdc(16'h00F7, 1'b1, 16'h0008, 1'b1);
    @(posedge ref_clk) programVoltagePin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wr(16'h00F7, 16'h0002, 1'b1);
    rdc(16'h00F7, 1'b1, 16'h0000, 1'b1);
    // override lets latch rise despite low voltage
    @(posedge ref_clk) testMode <= 1'b1;
    wr(16'h00F6, 16'h0008, 1'b1);
    rdc(16'h00F6, 1'b1, 16'h0008, 1'b1);
    wr(16'h00F7, 16'h0002, 1'b1);
    rdc(16'h00F7, 1'b1, 16'h0002, 1'b1);
    conclude();
  end
endmodule // testbench
